// ---- hdl/cache_params.svh ----
// Operation
// - allocate only on read miss; write miss bypasses
// - read miss allocates when access is cacheable
// - fill data cached only for cacheable reads
// - read hit served from cached data
// - line holds four words, tag, two state bits
// - state bits: 00 I, 01 E, 10 M, 11 S
// - write-through mode: write hit updates cache and memory
// - write hit on shared line also writes bus
// - write hit on exclusive/modified stays in cache
// - modified data written on replace or snoop hit
// - snoop hit on modified line updates memory first
// - snoop hit modified: back off master, write line
// - invalid lines never hit
// - fill uses an invalid way first
// - otherwise evict pseudo-LRU way of set
// - modified victim goes to copy-back buffer
// - policy pin low at reset forces write-through
// - write-back fill: policy high exclusive, low shared
// - page write-through attribute forces shared fill
// - write hit on exclusive becomes modified
`ifndef CACHE_PARAMS_SVH
`define CACHE_PARAMS_SVH

// ****************************************
// geometry
// ****************************************
`define SET_BITS 4
`define TAG_W 24
`define LINE_WORDS 4
`define WAYS 4

// ****************************************
// line state codes {high, low}
// ****************************************
`define ST_INV 2'b00
`define ST_EXC 2'b01
`define ST_MOD 2'b10
`define ST_SHR 2'b11

// ****************************************
// register offsets
// ****************************************
`define ADDR_CMD_ADDR 12'h000
`define ADDR_CMD_DATA 12'h004
`define ADDR_CMD 12'h008
`define ADDR_STATUS 12'h00c
`define ADDR_RDATA 12'h010

// ****************************************
// command fields and codes
// ****************************************
`define CMD_OP_LSB 0
`define CMD_PWT_BIT 2
`define CMD_CACHE_BIT 3
`define CMD_INV_BIT 4
`define OP_READ 2'h0
`define OP_WRITE 2'h1
`define OP_SNOOP 2'h2

// ****************************************
// status fields
// ****************************************
`define STAT_BUSY_BIT 0
`define STAT_HIT_BIT 1
`define STAT_WAY_LSB 2
`define STAT_STATE_LSB 4
`define STAT_WBMODE_BIT 6
`define STAT_CB_BIT 7
`define STAT_BACKOFF_BIT 8

`define RST_WORD 32'h0000_0000

`endif

// ---- hdl/cache_pkg.sv ----
`include "cache_params.svh"
package cache_pkg;

    typedef enum logic [2:0] {
        S_CLEAR, S_IDLE, S_LOOKUP, S_DECIDE, S_FILL, S_WEXT, S_DRAIN, S_SNOOP_WB
    } fsm_t;

    typedef struct packed {
        logic [`TAG_W-1:0] tag;
        logic [1:0] state;
        logic [`LINE_WORDS-1:0][31:0] data;
    } way_entry_t;

    typedef struct packed {
        logic [2:0] lru;
        way_entry_t [`WAYS-1:0] way;
    } set_entry_t;

    typedef struct packed {
        fsm_t fsm;
        logic [`SET_BITS-1:0] clr_idx;
        logic wb_mode;
        logic [31:0] cmd_addr;
        logic [31:0] cmd_wdata;
        logic [1:0] op;
        logic page_write_through_attr;
        logic cacheable;
        logic inv;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [31:0] rdata;
        logic hit;
        logic [1:0] way;
        logic [1:0] line_state;
        set_entry_t entry;
        logic wr_en;
        logic [`SET_BITS-1:0] wr_set;
        logic [1:0] beat;
        logic fill_wb;
        logic cb_valid;
        logic [31:0] cb_addr;
        logic [`LINE_WORDS-1:0][31:0] cb_data;
        logic ext_rd_req;
        logic ext_wr_req;
        logic [31:0] ext_addr;
        logic [31:0] ext_wdata;
        logic backoff_master;
    } ctrl_state_t;

endpackage

// ---- hdl/tag_mem_if.sv ----
`timescale 1ns/1ns
`include "cache_params.svh"
interface tag_mem_if;
    import cache_pkg::*;
    logic [`SET_BITS-1:0] rd_set;
    set_entry_t rd_entry;
    logic wr_en;
    logic [`SET_BITS-1:0] wr_set;
    set_entry_t wr_entry;
    modport ctrl (output rd_set, input rd_entry, output wr_en, output wr_set, output wr_entry);
    modport store (input rd_set, output rd_entry, input wr_en, input wr_set, input wr_entry);
endinterface

// ---- hdl/line_store.sv ----
`timescale 1ns/1ns
`include "cache_params.svh"
module line_store #(
    parameter int SETS = 16
) (
    input wire logic pclk,
    tag_mem_if.store bus
);
    import cache_pkg::*;

    // ****************************************
    // set array, registered read
    // ****************************************
    set_entry_t lines [SETS];
    set_entry_t rd_q;

    always_ff @(posedge pclk) begin
        rd_q <= lines[bus.rd_set];
        if (bus.wr_en) begin
            lines[bus.wr_set] <= bus.wr_entry;
        end
    end

    assign bus.rd_entry = rd_q;
endmodule

// ---- hdl/writeback_cache_line_state_ctrl.sv ----
`timescale 1ns/1ns
`include "cache_params.svh"
module writeback_cache_line_state_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic line_policy_select,
    input wire logic burst_ready_input,
    input wire logic [31:0] ext_rdata,
    output logic ext_rd_req,
    output logic ext_wr_req,
    output logic [31:0] ext_addr,
    output logic [31:0] ext_wdata,
    output logic backoff_master
);
    import cache_pkg::*;

    // ****************************************
    // state and line store
    // ****************************************
    ctrl_state_t st;
    ctrl_state_t next_st;

    tag_mem_if tmi ();

    line_store #(.SETS(2 ** `SET_BITS)) u_store (
        .pclk(pclk),
        .bus(tmi.store)
    );

    logic [`SET_BITS-1:0] idx;
    logic [`TAG_W-1:0] tagv;
    logic [1:0] wsel;
    logic [`WAYS-1:0] hit_vec;
    logic [`WAYS-1:0] inv_vec;
    logic hit_any;
    logic [1:0] hit_w;
    logic [1:0] first_inv;
    logic [1:0] victim;
    logic [1:0] hit_state;
    logic [1:0] victim_state;
    logic [31:0] hit_word;
    logic [`LINE_WORDS-1:0][31:0] victim_data;
    logic [`LINE_WORDS-1:0][31:0] src;
    logic [1:0] next_beat;
    logic [31:0] status;
    logic apb_wr;
    logic fill_done;

    assign idx = st.cmd_addr[`SET_BITS+3:4];
    assign tagv = st.cmd_addr[31:`SET_BITS+4];
    assign wsel = st.cmd_addr[3:2];
    assign next_beat = st.beat + 2'd1;
    assign tmi.rd_set = idx;
    assign tmi.wr_en = st.wr_en;
    assign tmi.wr_set = st.wr_set;
    assign tmi.wr_entry = st.entry;

    // ****************************************
    // tree recency helpers
    // ****************************************
    function automatic logic [1:0] plru_victim(input logic [2:0] t);
        plru_victim = t[0] ? {1'b1, t[2]} : {1'b0, t[1]};
    endfunction

    function automatic logic [2:0] plru_touch(input logic [2:0] t, input logic [1:0] w);
        logic [2:0] r;
        r = t;
        if (!w[1]) begin
            r[0] = 1'b1;
            r[1] = ~w[0];
        end else begin
            r[0] = 1'b0;
            r[2] = ~w[0];
        end
        return r;
    endfunction

    // ****************************************
    // lookup
    // ****************************************
    always_comb begin
        hit_w = 2'd0;
        first_inv = 2'd0;
        for (int w = `WAYS - 1; w >= 0; w--) begin
            inv_vec[w] = (tmi.rd_entry.way[w].state == `ST_INV);
            hit_vec[w] = !inv_vec[w] && (tmi.rd_entry.way[w].tag == tagv);
            if (hit_vec[w]) begin
                hit_w = 2'(w);
            end
            if (inv_vec[w]) begin
                first_inv = 2'(w);
            end
        end
        hit_any = |hit_vec;
        victim = (|inv_vec) ? first_inv : plru_victim(tmi.rd_entry.lru);
        hit_state = tmi.rd_entry.way[hit_w].state;
        victim_state = tmi.rd_entry.way[victim].state;
        hit_word = tmi.rd_entry.way[hit_w].data[wsel];
        victim_data = tmi.rd_entry.way[victim].data;
        src = (st.fsm == S_DRAIN) ? st.cb_data : st.entry.way[st.way].data;
        fill_done = (st.fsm == S_FILL) && burst_ready_input && st.cacheable && (st.beat == 2'd3);
    end

    always_comb begin
        status = `RST_WORD;
        status[`STAT_BUSY_BIT] = (st.fsm != S_IDLE);
        status[`STAT_HIT_BIT] = st.hit;
        status[`STAT_WAY_LSB +: 2] = st.way;
        status[`STAT_STATE_LSB +: 2] = st.line_state;
        status[`STAT_WBMODE_BIT] = st.wb_mode;
        status[`STAT_CB_BIT] = st.cb_valid;
        status[`STAT_BACKOFF_BIT] = st.backoff_master;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_st = st;
        next_st.pready = 1'b0;
        next_st.wr_en = 1'b0;
        apb_wr = psel && penable && st.pready && pwrite;
        if (psel && !penable) begin
            next_st.pready = 1'b1;
            next_st.pslverr = 1'b0;
            unique case (paddr)
                `ADDR_CMD_ADDR: next_st.prdata = st.cmd_addr;
                `ADDR_CMD_DATA: next_st.prdata = st.cmd_wdata;
                `ADDR_CMD: next_st.prdata = {27'h0, st.inv, st.cacheable, st.page_write_through_attr, st.op};
                `ADDR_STATUS: next_st.prdata = status;
                `ADDR_RDATA: next_st.prdata = st.rdata;
                default: begin
                    next_st.prdata = `RST_WORD;
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
        unique case (st.fsm)
            S_CLEAR: begin
                if (st.clr_idx == '0) begin
                    next_st.wb_mode = line_policy_select;
                end
                next_st.wr_en = 1'b1;
                next_st.wr_set = st.clr_idx;
                next_st.entry = '0;
                next_st.clr_idx = `SET_BITS'(st.clr_idx + 1'b1);
                if (&st.clr_idx) begin
                    next_st.fsm = S_IDLE;
                end
            end
            S_IDLE: begin
                if (apb_wr && paddr == `ADDR_CMD_ADDR) begin
                    next_st.cmd_addr = pwdata;
                end
                if (apb_wr && paddr == `ADDR_CMD_DATA) begin
                    next_st.cmd_wdata = pwdata;
                end
                if (apb_wr && paddr == `ADDR_CMD) begin
                    next_st.op = pwdata[`CMD_OP_LSB +: 2];
                    next_st.page_write_through_attr = pwdata[`CMD_PWT_BIT];
                    next_st.cacheable = pwdata[`CMD_CACHE_BIT];
                    next_st.inv = pwdata[`CMD_INV_BIT];
                    next_st.fsm = S_LOOKUP;
                end
            end
            S_LOOKUP: begin
                next_st.fsm = S_DECIDE;
            end
            S_DECIDE: begin
                next_st.entry = tmi.rd_entry;
                next_st.hit = hit_any;
                next_st.way = hit_any ? hit_w : victim;
                next_st.line_state = hit_any ? hit_state : `ST_INV;
                next_st.wr_set = idx;
                next_st.beat = 2'd0;
                next_st.fsm = S_IDLE;
                unique case (st.op)
                    `OP_READ: begin
                        if (hit_any) begin
                            next_st.rdata = hit_word;
                            next_st.entry.lru = plru_touch(tmi.rd_entry.lru, hit_w);
                            next_st.wr_en = 1'b1;
                        end else begin
                            next_st.ext_rd_req = 1'b1;
                            next_st.ext_addr = st.cacheable ? {st.cmd_addr[31:4], 4'h0}
                                                            : st.cmd_addr;
                            next_st.fsm = S_FILL;
                            if (st.cacheable && victim_state == `ST_MOD) begin
                                next_st.cb_valid = 1'b1;
                                next_st.cb_addr = {tmi.rd_entry.way[victim].tag, idx, 4'h0};
                                next_st.cb_data = victim_data;
                            end
                        end
                    end
                    `OP_WRITE: begin
                        next_st.ext_addr = st.cmd_addr;
                        next_st.ext_wdata = st.cmd_wdata;
                        if (hit_any) begin
                            next_st.entry.way[hit_w].data[wsel] = st.cmd_wdata;
                            next_st.entry.lru = plru_touch(tmi.rd_entry.lru, hit_w);
                            next_st.wr_en = 1'b1;
                            if (hit_state == `ST_SHR || !st.wb_mode) begin
                                next_st.ext_wr_req = 1'b1;
                                next_st.fsm = S_WEXT;
                            end else if (hit_state == `ST_EXC) begin
                                next_st.entry.way[hit_w].state = `ST_MOD;
                                next_st.line_state = `ST_MOD;
                            end
                        end else begin
                            next_st.ext_wr_req = 1'b1;
                            next_st.fsm = S_WEXT;
                        end
                    end
                    `OP_SNOOP: begin
                        if (hit_any && hit_state == `ST_MOD) begin
                            next_st.backoff_master = 1'b1;
                            next_st.ext_wr_req = 1'b1;
                            next_st.ext_addr = {st.cmd_addr[31:4], 4'h0};
                            next_st.ext_wdata = tmi.rd_entry.way[hit_w].data[0];
                            next_st.fsm = S_SNOOP_WB;
                        end else if (hit_any && st.inv) begin
                            next_st.entry.way[hit_w].state = `ST_INV;
                            next_st.wr_en = 1'b1;
                        end
                    end
                    default: begin
                        next_st.fsm = S_IDLE;
                    end
                endcase
            end
            S_FILL: begin
                if (burst_ready_input) begin
                    if (st.beat == 2'd0) begin
                        next_st.fill_wb = line_policy_select;
                    end
                    next_st.entry.way[st.way].data[st.beat] = ext_rdata;
                    if (!st.cacheable || st.beat == wsel) begin
                        next_st.rdata = ext_rdata;
                    end
                    if (st.cacheable) begin
                        next_st.ext_addr = {st.ext_addr[31:4], next_beat, 2'b00};
                    end
                    next_st.beat = next_beat;
                    if (!st.cacheable) begin
                        next_st.ext_rd_req = 1'b0;
                        next_st.fsm = S_IDLE;
                    end else if (st.beat == 2'd3) begin
                        next_st.ext_rd_req = 1'b0;
                        next_st.entry.way[st.way].tag = tagv;
                        if (!st.wb_mode || st.page_write_through_attr) begin
                            next_st.entry.way[st.way].state = `ST_SHR;
                        end else begin
                            next_st.entry.way[st.way].state = st.fill_wb ? `ST_EXC
                                                                         : `ST_SHR;
                        end
                        next_st.entry.lru = plru_touch(st.entry.lru, st.way);
                        next_st.wr_en = 1'b1;
                        next_st.line_state = next_st.entry.way[st.way].state;
                        next_st.fsm = S_IDLE;
                        if (st.cb_valid) begin
                            next_st.beat = 2'd0;
                            next_st.ext_wr_req = 1'b1;
                            next_st.ext_addr = st.cb_addr;
                            next_st.ext_wdata = st.cb_data[0];
                            next_st.fsm = S_DRAIN;
                        end
                    end
                end
            end
            S_WEXT: begin
                if (burst_ready_input) begin
                    next_st.ext_wr_req = 1'b0;
                    next_st.fsm = S_IDLE;
                end
            end
            S_DRAIN, S_SNOOP_WB: begin
                if (burst_ready_input) begin
                    next_st.beat = next_beat;
                    next_st.ext_addr = {st.ext_addr[31:4], next_beat, 2'b00};
                    next_st.ext_wdata = src[next_beat];
                    if (st.beat == 2'd3) begin
                        next_st.ext_wr_req = 1'b0;
                        next_st.fsm = S_IDLE;
                        if (st.fsm == S_DRAIN) begin
                            next_st.cb_valid = 1'b0;
                        end else begin
                            next_st.entry.way[st.way].state = st.inv ? `ST_INV : `ST_SHR;
                            next_st.line_state = next_st.entry.way[st.way].state;
                            next_st.wr_en = 1'b1;
                            next_st.backoff_master = 1'b0;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign ext_rd_req = st.ext_rd_req;
    assign ext_wr_req = st.ext_wr_req;
    assign ext_addr = st.ext_addr;
    assign ext_wdata = st.ext_wdata;
    assign backoff_master = st.backoff_master;

    // ****************************************
    // checks
    // ****************************************
    default clocking chk_clk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_decide(logic [1:0] kind);
        st.fsm == S_DECIDE && st.op == kind;
    endsequence

    sequence s_read_miss_alloc;
        s_decide(`OP_READ) ##0 (!hit_any && st.cacheable);
    endsequence

    property p_write_miss;
        s_decide(`OP_WRITE) ##0 !hit_any |=> st.fsm == S_WEXT && st.ext_wr_req && !st.wr_en;
    endproperty
    a_write_miss: assert property (p_write_miss) else $error("write miss allocated");

    property p_read_hit;
        s_decide(`OP_READ) ##0 hit_any |=> !st.ext_rd_req && st.rdata == $past(hit_word);
    endproperty
    a_read_hit: assert property (p_read_hit) else $error("read hit not from cache");

    property p_shared_write;
        s_decide(`OP_WRITE) ##0 (hit_any && hit_state == `ST_SHR)
            |=> st.ext_wr_req && st.wr_en;
    endproperty
    a_shared_write: assert property (p_shared_write) else $error("shared write skipped bus");

    property p_excl_write;
        s_decide(`OP_WRITE) ##0 (hit_any && hit_state == `ST_EXC && st.wb_mode)
            |=> st.wr_en && !st.ext_wr_req && st.entry.way[st.way].state == `ST_MOD;
    endproperty
    a_excl_write: assert property (p_excl_write) else $error("exclusive write wrong");

    property p_snoop_mod;
        s_decide(`OP_SNOOP) ##0 (hit_any && hit_state == `ST_MOD)
            |=> st.backoff_master && st.ext_wr_req ##1 st.backoff_master;
    endproperty
    a_snoop_mod: assert property (p_snoop_mod) else $error("snoop hit no backoff");

    property p_backoff_scope;
        st.backoff_master |-> st.fsm == S_SNOOP_WB;
    endproperty
    a_backoff_scope: assert property (p_backoff_scope) else $error("backoff outside wb");

    property p_fill_state;
        fill_done |=> st.wr_en && st.entry.way[st.way].state ==
            ((!st.wb_mode || st.page_write_through_attr) ? `ST_SHR : (st.fill_wb ? `ST_EXC : `ST_SHR));
    endproperty
    a_fill_state: assert property (p_fill_state) else $error("fill state wrong");

    property p_invalid_first;
        s_read_miss_alloc ##0 (|inv_vec) |=> st.way == $past(first_inv);
    endproperty
    a_invalid_first: assert property (p_invalid_first) else $error("invalid way skipped");

    property p_copyback;
        s_read_miss_alloc ##0 (victim_state == `ST_MOD)
            |=> st.cb_valid && st.cb_data == $past(victim_data);
    endproperty
    a_copyback: assert property (p_copyback) else $error("modified victim lost");

    property p_no_alloc;
        st.fsm == S_FILL && !st.cacheable |=> !st.wr_en;
    endproperty
    a_no_alloc: assert property (p_no_alloc) else $error("uncacheable read allocated");

endmodule

// ---- sim/ext_mem_model.sv ----
`timescale 1ns/1ns
module ext_mem_model (
    input wire logic pclk,
    input wire logic ext_rd_req,
    input wire logic ext_wr_req,
    input wire logic [31:0] ext_addr,
    output logic burst_ready_input,
    output logic [31:0] ext_rdata,
    output int rd_beats,
    output int wr_beats,
    output logic [31:0] last_wr_addr
);
    // ****************************************
    // slow memory: one beat every second cycle
    // ****************************************
    initial begin
        burst_ready_input = 1'b0;
        rd_beats = 0;
        wr_beats = 0;
        last_wr_addr = 32'h0000_0000;
    end
    // data off the beat is inverted so stale values never match
    assign ext_rdata = burst_ready_input ? (ext_addr ^ 32'ha5a5_0000) : ~ext_addr;
    always @(posedge pclk) begin
        burst_ready_input <= (ext_rd_req | ext_wr_req) & ~burst_ready_input;
        if (burst_ready_input && ext_rd_req) rd_beats <= rd_beats + 1;
        // a backed-off master would retry its access after this last beat
        if (burst_ready_input && ext_wr_req) begin
            wr_beats <= wr_beats + 1;
            last_wr_addr <= ext_addr;
        end
    end
endmodule

// ---- sim/writeback_cache_line_state_ctrl_bench.sv ----
`timescale 1ns/1ns
`include "cache_params.svh"
module writeback_cache_line_state_ctrl_bench;
    logic pclk, presetn, psel, penable, pwrite, pslverr, pready, line_policy_select;
    logic burst_ready_input, ext_rd_req, ext_wr_req, backoff_master, err, boff;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, ext_rdata, ext_addr, last_wr_addr, st, rd, ext_wdata, wd;
    int rd_beats, wr_beats, r0, w0, mismatches, compares;
    writeback_cache_line_state_ctrl i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_policy_select(line_policy_select),
        .burst_ready_input(burst_ready_input), .ext_rdata(ext_rdata), .ext_rd_req(ext_rd_req),
        .ext_wr_req(ext_wr_req), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .backoff_master(backoff_master));
    ext_mem_model i_mem (.pclk(pclk), .ext_rd_req(ext_rd_req), .ext_wr_req(ext_wr_req),
        .ext_addr(ext_addr), .burst_ready_input(burst_ready_input), .ext_rdata(ext_rdata),
        .rd_beats(rd_beats), .wr_beats(wr_beats), .last_wr_addr(last_wr_addr));
    // ****************************************
    // bus tasks
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [31:0] a, input logic [31:0] d, input logic [4:0] c);
        int n;
        r0 = rd_beats; w0 = wr_beats; boff = 1'b0; n = 0;
        apb(`ADDR_CMD_ADDR, 1'b1, a);
        apb(`ADDR_CMD_DATA, 1'b1, d);
        apb(`ADDR_CMD, 1'b1, {27'h0, c});
        do begin
            apb(`ADDR_STATUS, 1'b0, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 300);
        st = rd;
    endtask
    always @(posedge pclk) if (backoff_master === 1'b1 && ext_wr_req === 1'b1) boff <= 1'b1;
    always @(posedge pclk) if (burst_ready_input === 1'b1 && ext_wr_req === 1'b1) wd <= ext_wdata;
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_fill_hit;
        cmd(32'h0000_1014, 32'h0, 5'h08);
        check("fill_beats", rd_beats - r0, 4);
        check("fill_state", st[5:4], `ST_EXC);
        check("fill_way", st[3:2], 0);
        apb(`ADDR_RDATA, 1'b0, 32'h0);
        check("fill_data", rd, 32'ha5a5_1014);
        cmd(32'h0000_1014, 32'h0, 5'h08);
        check("hit_flag", st[1], 1);
        check("hit_beats", rd_beats - r0, 0);
    endtask
    task automatic t_write_hit;
        cmd(32'h0000_1014, 32'h1234_5678, 5'h09);
        check("wr_hit_bus", wr_beats - w0, 0);
        check("wr_hit_state", st[5:4], `ST_MOD);
        cmd(32'h0000_1014, 32'h0, 5'h08);
        apb(`ADDR_RDATA, 1'b0, 32'h0);
        check("wr_hit_data", rd, 32'h1234_5678);
    endtask
    task automatic t_write_miss;
        cmd(32'h0000_2024, 32'h0bad_0001, 5'h09);
        check("wr_miss_bus", wr_beats - w0, 1);
        check("wr_miss_addr", last_wr_addr, 32'h0000_2024);
        check("wr_miss_data", wd, 32'h0bad_0001);
        cmd(32'h0000_2024, 32'h0, 5'h02);
        check("wr_miss_alloc", st[1], 0);
        cmd(32'h0000_5050, 32'h0, 5'h00);
        check("nc_beats", rd_beats - r0, 1);
        apb(`ADDR_RDATA, 1'b0, 32'h0);
        check("nc_data", rd, 32'ha5a5_5050);
        cmd(32'h0000_5050, 32'h0, 5'h02);
        check("nc_alloc", st[1], 0);
    endtask
    task automatic t_pwt;
        cmd(32'h0000_3038, 32'h0, 5'h0c);
        check("pwt_state", st[5:4], `ST_SHR);
        cmd(32'h0000_3038, 32'h5555_aaaa, 5'h09);
        check("shr_bus", wr_beats - w0, 1);
        check("shr_state", st[5:4], `ST_SHR);
    endtask
    task automatic t_evict;
        for (int i = 1; i < 4; i++) begin
            cmd({16'h0, 4'h1, i[3:0], 8'h10}, 32'h0, 5'h08);
            check("evict_fill_way", st[3:2], i);
        end
        cmd(32'h0000_1410, 32'h0, 5'h08);
        check("victim_way", st[3:2], 0);
        check("copyback_beats", wr_beats - w0, 4);
        check("copyback_addr", last_wr_addr, 32'h0000_101c);
        check("copyback_data", wd, 32'ha5a5_101c);
    endtask
    task automatic t_snoop;
        cmd(32'h0000_4040, 32'h0, 5'h08);
        cmd(32'h0000_4040, 32'h7777_0000, 5'h09);
        cmd(32'h0000_4040, 32'h0, 5'h12);
        check("snoop_beats", wr_beats - w0, 4);
        check("snoop_backoff", boff, 1);
        check("snoop_data", wd, 32'ha5a5_404c);
        check("snoop_done_backoff", backoff_master, 0);
        cmd(32'h0000_4040, 32'h0, 5'h02);
        check("snoop_inv", st[1], 0);
    endtask
    task report_and_stop;
        if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        #400000;
        mismatches++;
        report_and_stop;
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; line_policy_select = 1'b1; mismatches = 0; compares = 0; boff = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        cmd(32'h0, 32'h0, 5'h03);
        check("wb_mode", st[6], 1);
        apb(12'h020, 1'b0, 32'h0);
        check("unmapped_err", err, 1);
        t_fill_hit;
        t_write_hit;
        t_write_miss;
        t_pwt;
        t_evict;
        t_snoop;
        report_and_stop;
    end
endmodule
